// ===== rtl/ebt_pkg.sv
// Package: register map, field layout and timing constants of the 8-bit timer control block
package ebt_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SERIAL_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_COUNTER       = 8'h08;
  localparam logic [7:0] ADDR_CONST_A       = 8'h0C;
  localparam logic [7:0] ADDR_CONST_B       = 8'h10;
  localparam logic [7:0] ADDR_STATUS        = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h18;
  // ==========================================================================
  // Field positions in timer_control
  localparam int CKS_LSB         = 0;
  localparam int CKS_MSB         = 2;
  localparam int CCLR_LSB        = 3;
  localparam int CCLR_MSB        = 4;
  localparam int OVERFLOW_EN_BIT = 5;
  localparam int MATCH_A_EN_BIT  = 6;
  localparam int MATCH_B_EN_BIT  = 7;
  // Field positions in status, mask and serial_timer_config
  localparam int FLAG_WRAP = 5;
  localparam int FLAG_CMA  = 6;
  localparam int FLAG_CMB  = 7;
  localparam int ICKS_LSB  = 0;
  localparam int ICKS_MSB  = 1;
  // ==========================================================================
  // Reset values and counter maximum
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CONST_RESET = 8'hFF;
  localparam logic [7:0] CNT_RESET   = 8'h00;
  localparam logic [7:0] CNT_MAX     = 8'hFF;
  // ==========================================================================
  // Clock select codes
  localparam logic [2:0] CKS_OFF0  = 3'h0;
  localparam logic [2:0] CKS_INT   = 3'h1;
  localparam logic [2:0] CKS_DIV2  = 3'h2;
  localparam logic [2:0] CKS_DIV512 = 3'h3;
  localparam logic [2:0] CKS_OFF1  = 3'h4;
  localparam logic [2:0] CKS_EXT_R = 3'h5;
  localparam logic [2:0] CKS_EXT_F = 3'h6;
  localparam logic [2:0] CKS_EXT_B = 3'h7;
  // Clear select codes
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_CMA  = 2'h1;
  localparam logic [1:0] CCLR_CMB  = 2'h2;
  localparam logic [1:0] CCLR_EXT  = 2'h3;
  // ==========================================================================
  // Prescaler: internal divide-by-8, 64, 128 or 1024 for code 001 per input clock select
  localparam int PRESC_W = 10;
  localparam int DIV2_BIT   = 0;
  localparam int DIV512_BIT = 8;
  localparam int INT_BIT_L0 = 2;
  localparam int INT_BIT_L1 = 5;
  localparam int INT_BIT_H0 = 6;
  localparam int INT_BIT_H1 = 9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ebt_pkg

// ===== rtl/ebt_timer.sv
// Module: 8-bit timer channel control with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none

module ebt_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // Write response channel
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // Read data channel
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        ext_clock_pin,
  input  wire logic        ext_reset_pin,
  // Interrupt and per-source requests
  output var  logic        irq,
  output var  logic        overflow_request,
  output var  logic        match_a_request,
  output var  logic        match_b_request
);
  // ==========================================================================
  // Registers
  logic [7:0] timer_control_reg;
  logic [7:0] serial_timer_config_reg;
  logic [7:0] eight_bit_counter_reg;
  logic [7:0] time_constant_a_reg;
  logic [7:0] time_constant_b_reg;
  logic [7:0] status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] flag_seen_reg;
  logic [ebt_pkg::PRESC_W-1:0] presc_reg;
  logic [ebt_pkg::PRESC_W-1:0] presc_prev_reg;
  logic [1:0] ext_clk_sync_reg;
  logic [1:0] ext_rst_sync_reg;
  logic       ext_clk_prev_reg;
  logic       ext_rst_prev_reg;

  // Bus state
  logic [7:0]  awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;

  // Field views
  logic [2:0] clock_select;
  logic [1:0] clear_select;
  logic [1:0] input_clock_sel;
  assign clock_select    = timer_control_reg[ebt_pkg::CKS_MSB:ebt_pkg::CKS_LSB];
  assign clear_select    = timer_control_reg[ebt_pkg::CCLR_MSB:ebt_pkg::CCLR_LSB];
  assign input_clock_sel = serial_timer_config_reg[ebt_pkg::ICKS_MSB:ebt_pkg::ICKS_LSB];

  // Falling edge of one prescaler tap
  function automatic logic tap_fall(input logic [ebt_pkg::PRESC_W-1:0] prev,
                                    input logic [ebt_pkg::PRESC_W-1:0] cur,
                                    input int unsigned idx);
    tap_fall = prev[idx] & ~cur[idx];
  endfunction : tap_fall

  // ==========================================================================
  // Pin synchronisers and edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_clk_sync_reg <= 2'h0;
      ext_rst_sync_reg <= 2'h0;
      ext_clk_prev_reg <= 1'b0;
      ext_rst_prev_reg <= 1'b0;
    end else begin
      ext_clk_sync_reg <= {ext_clk_sync_reg[0], ext_clock_pin};
      ext_rst_sync_reg <= {ext_rst_sync_reg[0], ext_reset_pin};
      ext_clk_prev_reg <= ext_clk_sync_reg[1];
      ext_rst_prev_reg <= ext_rst_sync_reg[1];
    end
  end

  logic ext_rise;
  logic ext_fall;
  logic ext_rst_rise;
  assign ext_rise     = ext_clk_sync_reg[1] & ~ext_clk_prev_reg;
  assign ext_fall     = ~ext_clk_sync_reg[1] & ext_clk_prev_reg;
  assign ext_rst_rise = ext_rst_sync_reg[1] & ~ext_rst_prev_reg;

  // Free-running prescaler of the peripheral clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg      <= '0;
      presc_prev_reg <= '0;
    end else begin
      presc_reg      <= presc_reg + 1'b1;
      presc_prev_reg <= presc_reg;
    end
  end

  // Internal tap for code 001, chosen by the input clock select bits
  logic int_tick;
  always_comb begin
    unique case (input_clock_sel)
      2'h0:    int_tick = tap_fall(presc_prev_reg, presc_reg, ebt_pkg::INT_BIT_L0);
      2'h1:    int_tick = tap_fall(presc_prev_reg, presc_reg, ebt_pkg::INT_BIT_L1);
      2'h2:    int_tick = tap_fall(presc_prev_reg, presc_reg, ebt_pkg::INT_BIT_H0);
      default: int_tick = tap_fall(presc_prev_reg, presc_reg, ebt_pkg::INT_BIT_H1);
    endcase
  end

  // Count enable from the selected source
  logic count_tick;
  always_comb begin
    unique case (clock_select)
      ebt_pkg::CKS_OFF0, ebt_pkg::CKS_OFF1: count_tick = 1'b0;
      ebt_pkg::CKS_INT:    count_tick = int_tick;
      ebt_pkg::CKS_DIV2:   count_tick = tap_fall(presc_prev_reg, presc_reg,
                                                 ebt_pkg::DIV2_BIT);
      ebt_pkg::CKS_DIV512: count_tick = tap_fall(presc_prev_reg, presc_reg,
                                                 ebt_pkg::DIV512_BIT);
      ebt_pkg::CKS_EXT_R:  count_tick = ext_rise;
      ebt_pkg::CKS_EXT_F:  count_tick = ext_fall;
      default:             count_tick = ext_rise | ext_fall;
    endcase
  end

  // Compare and clear conditions
  logic match_a;
  logic match_b;
  logic do_clear;
  logic wrap;
  assign match_a = (eight_bit_counter_reg == time_constant_a_reg);
  assign match_b = (eight_bit_counter_reg == time_constant_b_reg);
  assign wrap    = count_tick & (eight_bit_counter_reg == ebt_pkg::CNT_MAX);
  always_comb begin
    unique case (clear_select)
      ebt_pkg::CCLR_NONE: do_clear = 1'b0;
      ebt_pkg::CCLR_CMA:  do_clear = match_a;
      ebt_pkg::CCLR_CMB:  do_clear = match_b;
      default:            do_clear = ext_rst_rise;
    endcase
  end

  // ==========================================================================
  // AXI4-Lite write path
  logic wr_fire;
  logic wr_ok;
  logic rd_fire;
  logic [7:0] wbyte;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_ok   = wr_fire & wstrb_reg[0];
  assign wbyte   = wdata_reg[7:0];
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  // Address and data capture in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_reg   <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ebt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (awaddr_reg)
        ebt_pkg::ADDR_TIMER_CONTROL, ebt_pkg::ADDR_SERIAL_CONFIG, ebt_pkg::ADDR_COUNTER,
        ebt_pkg::ADDR_CONST_A, ebt_pkg::ADDR_CONST_B, ebt_pkg::ADDR_STATUS,
        ebt_pkg::ADDR_IRQ_MASK: s_axi_bresp <= ebt_pkg::RESP_OKAY;
        default:                s_axi_bresp <= ebt_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and constant registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_reg       <= ebt_pkg::CTRL_RESET;
      serial_timer_config_reg <= ebt_pkg::CTRL_RESET;
      time_constant_a_reg     <= ebt_pkg::CONST_RESET;
      time_constant_b_reg     <= ebt_pkg::CONST_RESET;
      irq_mask_reg            <= ebt_pkg::CTRL_RESET;
    end else if (wr_ok) begin
      if (awaddr_reg == ebt_pkg::ADDR_TIMER_CONTROL) timer_control_reg <= wbyte;
      if (awaddr_reg == ebt_pkg::ADDR_SERIAL_CONFIG) serial_timer_config_reg <= wbyte;
      if (awaddr_reg == ebt_pkg::ADDR_CONST_A) time_constant_a_reg <= wbyte;
      if (awaddr_reg == ebt_pkg::ADDR_CONST_B) time_constant_b_reg <= wbyte;
      if (awaddr_reg == ebt_pkg::ADDR_IRQ_MASK) irq_mask_reg <= wbyte;
    end
  end

  // Counter: clear wins over increment, software write lowest
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eight_bit_counter_reg <= ebt_pkg::CNT_RESET;
    end else if (do_clear) begin
      eight_bit_counter_reg <= ebt_pkg::CNT_RESET;
    end else if (count_tick) begin
      eight_bit_counter_reg <= eight_bit_counter_reg + 8'h01;
    end else if (wr_ok && awaddr_reg == ebt_pkg::ADDR_COUNTER) begin
      eight_bit_counter_reg <= wbyte;
    end
  end

  // ==========================================================================
  // Status flags: set wins; a status read clears all flags, as does a written zero after a read as one
  logic [7:0] flag_set;
  logic       st_wr;
  logic       st_rd;
  assign flag_set = {match_b, match_a, wrap, 5'h00};
  assign st_wr    = wr_ok & (awaddr_reg == ebt_pkg::ADDR_STATUS);
  assign st_rd    = rd_fire & (s_axi_araddr == ebt_pkg::ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg    <= 8'h00;
      flag_seen_reg <= 8'h00;
    end else begin
      // Clear by read: read hands back the flags then drops them
      status_reg <= flag_set | (status_reg & ~(st_rd ? status_reg : 8'h00)
                    & ~(st_wr ? (flag_seen_reg & ~wbyte) : 8'h00));
      if (st_rd) begin
        flag_seen_reg <= status_reg;
      end else if (st_wr) begin
        flag_seen_reg <= 8'h00;
      end
    end
  end

  // Requests gated by the enables; irq gated by the mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_request <= 1'b0;
      match_a_request  <= 1'b0;
      match_b_request  <= 1'b0;
      irq              <= 1'b0;
    end else begin
      overflow_request <= status_reg[ebt_pkg::FLAG_WRAP]
                          & timer_control_reg[ebt_pkg::OVERFLOW_EN_BIT];
      match_a_request  <= status_reg[ebt_pkg::FLAG_CMA]
                          & timer_control_reg[ebt_pkg::MATCH_A_EN_BIT];
      match_b_request  <= status_reg[ebt_pkg::FLAG_CMB]
                          & timer_control_reg[ebt_pkg::MATCH_B_EN_BIT];
      irq              <= |(status_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ebt_pkg::ADDR_TIMER_CONTROL: rd_byte = timer_control_reg;
      ebt_pkg::ADDR_SERIAL_CONFIG: rd_byte = serial_timer_config_reg;
      ebt_pkg::ADDR_COUNTER:       rd_byte = eight_bit_counter_reg;
      ebt_pkg::ADDR_CONST_A:       rd_byte = time_constant_a_reg;
      ebt_pkg::ADDR_CONST_B:       rd_byte = time_constant_b_reg;
      ebt_pkg::ADDR_STATUS:        rd_byte = status_reg;
      ebt_pkg::ADDR_IRQ_MASK:      rd_byte = irq_mask_reg;
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ebt_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : ebt_timer

`default_nettype wire

// ===== verif/ebt_timer_monitor.sv
// Port checker for the timer control block
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module ebt_timer_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Requests
  input wire logic        irq,
  input wire logic        overflow_request,
  input wire logic        match_a_request,
  input wire logic        match_b_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Answer timing and holding of bus outputs
  AST_WRITE_ANSWER: assert property ($fell(s_axi_awready) && $fell(s_axi_wready)
    |=> s_axi_bvalid) else $error("write response missing");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_WRITE_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  AST_READ_ANSWER: assert property ($fell(s_axi_arready) |-> s_axi_rvalid)
    else $error("read data missing");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_READ_RETURN: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not retired");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == ebt_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("refused read not zero");
  AST_REQ_RESET: assert property ($rose(aresetn) |-> !(irq || overflow_request
    || match_a_request || match_b_request)) else $error("request after reset");
  // Main scenarios reached
  COV_WRITE_ERR: cover property (s_axi_bvalid && s_axi_bresp == ebt_pkg::RESP_SLVERR);
  COV_IRQ: cover property ($rose(irq));
  COV_MATCH_B: cover property ($rose(match_b_request));
endmodule : ebt_timer_monitor

bind ebt_timer ebt_timer_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq), .overflow_request(overflow_request),
  .match_a_request(match_a_request), .match_b_request(match_b_request));
`default_nettype wire

// ===== verif/ebt_pins.sv
// Model of the external count clock and counter clear pins
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Pin driver
module ebt_pins (
  // Clock
  input  wire logic aclk,
  // Pins
  output var  logic ext_clock_pin,
  output var  logic ext_reset_pin
);
  // Both pins rest low between pulses
  initial begin
    ext_clock_pin = 1'b0;
    ext_reset_pin = 1'b0;
  end
  // Count clock pulses, each level held 4 cycles to pass the synchroniser
  task automatic clk_pulses(input int n);
    repeat (n) begin
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clock_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask : clk_pulses
  // One clear pulse on the reset pin
  task automatic rst_pulse;
    ext_reset_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_reset_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : rst_pulse
endmodule : ebt_pins
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench top
module tb_top;
  localparam logic [7:0] A_TC  = ebt_pkg::ADDR_TIMER_CONTROL;
  localparam logic [7:0] A_CNT = ebt_pkg::ADDR_COUNTER;
  localparam logic [7:0] A_STS = ebt_pkg::ADDR_STATUS;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00, v;
  logic [31:0]      wd = 32'h0000_0000;
  logic [3:0]       ws = 4'h1;
  logic             awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  wire logic        awready, wready, bvalid, arready, rvalid, irq, ovr, mar, mbr, eck, erst;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int               errors = 0, n_compared = 0, cyc = 0;
  // Clock
  always #25 aclk = ~aclk;
  // Design and pin model
  ebt_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clock_pin(eck),
    .ext_reset_pin(erst), .irq(irq), .overflow_request(ovr), .match_a_request(mar),
    .match_b_request(mbr));
  ebt_pins pins (.aclk(aclk), .ext_clock_pin(eck), .ext_reset_pin(erst));
  // Verdict and end of run
  task automatic final_report;
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = ebt_pkg::RESP_OKAY,
                    input logic [3:0] st = 4'h1);
    logic got;
    got = 1'b0;
    awaddr <= a;
    wd <= {24'hA5_A5A5, d}; // Upper lanes carry junk the design must ignore
    ws <= st;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk(bresp, er);
      end
    end
    // One edge apart so a following call never reassigns in this step
    @(posedge aclk);
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    input logic [1:0] er = ebt_pkg::RESP_OKAY);
    logic got;
    got = 1'b0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        d = rdata[7:0];
        chk({rdata[31:8], rresp}, {24'h00_0000, er});
      end
    end
    // One edge apart so a following call never reassigns in this step
    @(posedge aclk);
  endtask : rd
  // Read and compare
  task automatic rchk(input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  // Reset values and an unmapped address
  task automatic t_regs;
    rchk(A_TC, 8'h00);
    wr(A_TC, 8'hFF, ebt_pkg::RESP_OKAY, 4'h0);
    rchk(A_TC, 8'h00);
    rchk(ebt_pkg::ADDR_CONST_B, 8'hFF);
    rchk(A_STS, 8'h00);
    wr(8'h1C, 8'h5A, ebt_pkg::RESP_SLVERR);
    rd(8'h1C, v, ebt_pkg::RESP_SLVERR);
    chk(v, 8'h00);
  endtask : t_regs
  // Stop codes leave the counter untouched
  task automatic t_stop;
    for (int i = 0; i < 2; i++) begin
      wr(A_CNT, 8'h10);
      wr(A_TC, i ? 8'h04 : 8'h00);
      pins.clk_pulses(2);
      rchk(A_CNT, 8'h10);
    end
  endtask : t_stop
  // Internal sources: a window of four periods gives about four counts
  task automatic t_internal;
    int dv[6] = '{8, 64, 128, 1024, 2, 512};
    for (int i = 0; i < 6; i++) begin
      wr(A_CNT, 8'h00);
      wr(ebt_pkg::ADDR_SERIAL_CONFIG, 8'(i % 4));
      wr(A_TC, i < 4 ? 8'h01 : 8'(i - 2));
      repeat (4 * dv[i]) @(posedge aclk);
      wr(A_TC, 8'h00);
      rd(A_CNT, v);
      chk(v >= 8'h03 && v <= 8'(5 + 8 / dv[i]), 1'b1);
    end
  endtask : t_internal
  // External edges: rising, falling, both
  task automatic t_ext;
    for (int i = 5; i < 8; i++) begin
      wr(A_CNT, 8'h00);
      wr(A_TC, 8'(i));
      pins.clk_pulses(3);
      repeat (6) @(posedge aclk);
      wr(A_TC, 8'h00);
      rchk(A_CNT, i == 7 ? 8'h06 : 8'h03);
    end
  endtask : t_ext
  // Reset pin clears only when selected
  task automatic t_clear;
    wr(A_CNT, 8'h40);
    pins.rst_pulse;
    rchk(A_CNT, 8'h40);
    wr(A_TC, 8'h18);
    pins.rst_pulse;
    rchk(A_CNT, 8'h00);
    wr(A_TC, 8'h00);
  endtask : t_clear
  // Overflow flag, its enable, the mask and the flag clear
  task automatic t_ovf;
    wr(ebt_pkg::ADDR_IRQ_MASK, 8'h20);
    wr(A_CNT, 8'hFE);
    wr(A_TC, 8'h25);
    pins.clk_pulses(2);
    repeat (4) @(posedge aclk);
    chk({ovr, irq}, 2'b11);
    rchk(A_CNT, 8'h00);
    rchk(A_STS, 8'hE0);
    repeat (3) @(posedge aclk);
    chk({ovr, irq}, 2'b00);
    wr(A_STS, 8'hE0);
    rchk(A_STS, 8'h00);
    wr(A_TC, 8'h05);
    wr(A_CNT, 8'hFF);
    pins.clk_pulses(1);
    repeat (4) @(posedge aclk);
    chk({ovr, irq}, 2'b01);
    rd(A_STS, v);
  endtask : t_ovf
  // Compare-match clears and their request enables
  task automatic t_match;
    wr(ebt_pkg::ADDR_CONST_A, 8'h03);
    wr(A_CNT, 8'h00);
    wr(A_TC, 8'h4D);
    pins.clk_pulses(5);
    repeat (4) @(posedge aclk);
    chk({mar, mbr}, 2'b10);
    rchk(A_CNT, 8'h02);
    rd(A_STS, v);
    wr(ebt_pkg::ADDR_CONST_B, 8'h02);
    wr(A_CNT, 8'h00);
    wr(A_TC, 8'h95);
    pins.clk_pulses(4);
    repeat (4) @(posedge aclk);
    chk({mar, mbr}, 2'b01);
    rchk(A_CNT, 8'h00);
  endtask : t_match
  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_stop;
    t_internal;
    t_ext;
    t_clear;
    t_ovf;
    t_match;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
